// >>> core/pcse_top.sv
`timescale 1ns/1ps
`include "pcse_cfg.svh"

// ----------------------------------------------------------------
// ----------------------------------------------------------------

module pcse_top #(
    parameter int unsigned FAST_TICK_CYC = `PCSE_FAST_TICK_CYC,
    parameter int unsigned SLOW_TICK_CYC = `PCSE_SLOW_TICK_CYC
) (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST_B,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic [2:0]  I_PAD_IN,
    output logic      [2:0]  O_PAD_OUT,
    output logic      [2:0]  O_PAD_OE,
    output logic      [2:0]  O_PAD_PD,
    input  wire logic        I_PWM,
    input  wire logic        I_SLEEP,
    input  wire logic        I_PWR_OFF_RST,
    input  wire logic [1:0]  I_SEQ_ASSIGN,
    input  wire logic [1:0]  I_BOOT_DIR
);

    localparam logic [11:0] FAST_LAST = 12'(FAST_TICK_CYC - 1);
    localparam logic [22:0] SLOW_LAST = 23'(SLOW_TICK_CYC - 1);
    localparam logic [1:0]  NO_PAD    = 2'h3;

    pcse_pkg::pcse_top_s s;
    pcse_pkg::pcse_top_s next_s;
    logic [2:0]          level;
    logic [1:0]          idx;
    logic [1:0]          k;
    logic                setup;
    logic                wr_acc;

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    function automatic logic [1:0] pad_of(input logic [11:0] a);
        logic [1:0] r;
        r = NO_PAD;
        if (a[1:0] == 2'h0) begin
            if (a[11:2] == `PCSE_PIN6_IDX) begin
                r = 2'h0;
            end else if (a[11:2] == `PCSE_PIN7_IDX) begin
                r = 2'h1;
            end else if (a[11:2] == `PCSE_PIN8_IDX) begin
                r = 2'h2;
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] rd_byte(
        input pcse_pkg::pcse_pad_s p,
        input logic                lvl,
        input logic [1:0]          n
    );
        logic [7:0] r;
        r = 8'h00;
        r[`PCSE_BIT_DEB]   = p.deb;
        r[`PCSE_BIT_PDEN]  = p.pden;
        r[`PCSE_BIT_DIR]   = p.dir;
        r[`PCSE_BIT_LEVEL] = lvl;
        r[`PCSE_BIT_SET]   = p.set;
        if (n == 2'h2) begin
            r[`PCSE_BIT_SEL] = p.sel;
        end else begin
            r[`PCSE_BIT_SLEEP] = p.sleep;
        end
        return r;
    endfunction

    assign idx    = pad_of(I_PADDR);
    assign k      = (idx == NO_PAD) ? 2'h0 : idx;
    assign setup  = I_PSEL && !I_PENABLE;
    assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE && idx != NO_PAD;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;

        // first flop only feeds the second
        next_s.sync1 = I_PAD_IN;
        next_s.sync2 = s.sync1;

        next_s.fast_tick = (s.fast_cnt == FAST_LAST);
        next_s.fast_cnt  = next_s.fast_tick ? 12'h000 : s.fast_cnt + 12'h001;
        next_s.slow_tick = (s.slow_cnt == SLOW_LAST);
        next_s.slow_cnt  = next_s.slow_tick ? 23'h000000 : s.slow_cnt + 23'h000001;

        // read data is built in the setup cycle so it leaves a flop
        if (setup) begin
            next_s.slverr = (idx == NO_PAD);
            next_s.rdata  = (idx == NO_PAD) ? 8'h00 : rd_byte(s.pad[k], level[k], k);
        end

        if (wr_acc) begin
            next_s.pad[k].deb  = I_PWDATA[`PCSE_BIT_DEB];
            next_s.pad[k].pden = I_PWDATA[`PCSE_BIT_PDEN];
            next_s.pad[k].dir  = I_PWDATA[`PCSE_BIT_DIR];
            next_s.pad[k].set  = I_PWDATA[`PCSE_BIT_SET];
            if (k == 2'h2) begin
                next_s.pad[k].sel = I_PWDATA[`PCSE_BIT_SEL];
            end else begin
                next_s.pad[k].sleep = I_PWDATA[`PCSE_BIT_SLEEP];
            end
        end

        // boot straps are taken one edge after reset release
        if (s.boot_pend) begin
            next_s.boot_pend  = 1'b0;
            next_s.pad[0].dir = I_BOOT_DIR[0];
            next_s.pad[1].dir = I_BOOT_DIR[1];
        end

        // power-off reset outranks a write in the same cycle
        for (int i = 0; i < 2; i++) begin
            if (I_PWR_OFF_RST && I_SEQ_ASSIGN[i]) begin
                next_s.pad[i].pden = `PCSE_OFF_PDEN;
                next_s.pad[i].dir  = `PCSE_OFF_DIR;
                next_s.pad[i].set  = `PCSE_RST_SET;
            end
        end

        for (int i = 0; i < 3; i++) begin
            next_s.pad_oe[i] = s.pad[i].dir;
            next_s.pad_out[i] = s.pad[i].set;
            next_s.pad_pd[i] = s.pad[i].pden;
        end
        if (s.pad[2].sel) begin
            next_s.pad_out[2] = I_PWM;
        end
        for (int i = 0; i < 2; i++) begin
            if (I_SLEEP && s.pad[i].sleep) begin
                next_s.pad_oe[i]  = 1'b1;
                next_s.pad_out[i] = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            for (int i = 0; i < 3; i++) begin
                s.pad[i].sleep <= `PCSE_RST_SLEEP;
                s.pad[i].sel   <= `PCSE_RST_SEL;
                s.pad[i].deb   <= `PCSE_RST_DEB;
                s.pad[i].pden  <= `PCSE_RST_PDEN;
                s.pad[i].dir   <= `PCSE_RST_DIR;
                s.pad[i].set   <= `PCSE_RST_SET;
            end
            s.boot_pend <= 1'b1;
            s.sync1     <= {3{`PCSE_RST_LEVEL}};
            s.sync2     <= {3{`PCSE_RST_LEVEL}};
            s.fast_cnt  <= 12'h000;
            s.slow_cnt  <= 23'h000000;
            s.fast_tick <= 1'b0;
            s.slow_tick <= 1'b0;
            s.rdata     <= 8'h00;
            s.slverr    <= 1'b0;
            s.pad_out   <= 3'h0;
            s.pad_oe    <= 3'h0;
            s.pad_pd    <= {3{`PCSE_RST_PDEN}};
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // input filters, one per pad
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_deb
        pcse_debounce u_deb (
            .i_clk   (I_CORE_CLK),
            .i_rst_b (I_RST_B),
            .i_raw   (s.sync2[g]),
            .i_tick  (s.pad[g].deb ? s.slow_tick : s.fast_tick),
            .o_level (level[g])
        );
    end

    assign O_PRDATA  = {24'h000000, s.rdata};
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = s.slverr;
    assign O_PAD_OUT = s.pad_out;
    assign O_PAD_OE  = s.pad_oe;
    assign O_PAD_PD  = s.pad_pd;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_B);

    sequence s_rd_setup(logic [1:0] n);
        setup && !I_PWRITE && idx == n;
    endsequence

    property p_sleep_low;
        (I_SLEEP && s.pad[0].sleep) |=> (O_PAD_OE[0] && !O_PAD_OUT[0]);
    endproperty
    a_sleep_low: assert property (p_sleep_low)
        else $error("sleeping pad not forced low");

    property p_pd_follow;
        ##1 O_PAD_PD[1] == $past(s.pad[1].pden);
    endproperty
    a_pd_follow: assert property (p_pd_follow)
        else $error("pulldown does not follow its bit");

    property p_off_rst;
        (I_PWR_OFF_RST && I_SEQ_ASSIGN[0]) |=>
            (!s.pad[0].pden && s.pad[0].dir && !s.pad[0].set);
    endproperty
    a_off_rst: assert property (p_off_rst)
        else $error("power-off reset did not act on pad six");

    property p_dir_in;
        (!s.pad[2].dir) |=> !O_PAD_OE[2];
    endproperty
    a_dir_in: assert property (p_dir_in)
        else $error("input pad is driven");

    property p_boot_dir;
        (s.boot_pend && !I_PWR_OFF_RST) |=> s.pad[1].dir == $past(I_BOOT_DIR[1]);
    endproperty
    a_boot_dir: assert property (p_boot_dir)
        else $error("boot direction not taken");

    property p_level_rd;
        s_rd_setup(2'h0) |=> O_PRDATA[1] == $past(level[0]);
    endproperty
    a_level_rd: assert property (p_level_rd)
        else $error("pad level not read back");

    property p_set_out;
        (!I_SLEEP && s.pad[1].dir) |=> O_PAD_OUT[1] == $past(s.pad[1].set);
    endproperty
    a_set_out: assert property (p_set_out)
        else $error("output value not driven");

    property p_pwm_out;
        (s.pad[2].dir && s.pad[2].sel) |=> O_PAD_OUT[2] == $past(I_PWM);
    endproperty
    a_pwm_out: assert property (p_pwm_out)
        else $error("pwm not routed to pad eight");

    property p_rsvd;
        s_rd_setup(2'h2) |=> O_PRDATA[31:6] == 26'h0000000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits read nonzero");

    property p_pend_once;
        s.boot_pend |=> !s.boot_pend [*2];
    endproperty
    a_pend_once: assert property (p_pend_once)
        else $error("boot load repeated");

endmodule

// >>> pkg/pcse_cfg.svh
`ifndef PCSE_CFG_SVH
`define PCSE_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PCSE_PIN6_IDX 10'h066
`define PCSE_PIN7_IDX 10'h067
`define PCSE_PIN8_IDX 10'h068

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCSE_BIT_SLEEP 7
`define PCSE_BIT_SEL   5
`define PCSE_BIT_DEB   4
`define PCSE_BIT_PDEN  3
`define PCSE_BIT_DIR   2
`define PCSE_BIT_LEVEL 1
`define PCSE_BIT_SET   0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PCSE_RST_SLEEP 1'b0
`define PCSE_RST_SEL   1'b0
`define PCSE_RST_DEB   1'b0
`define PCSE_RST_PDEN  1'b1
`define PCSE_RST_DIR   1'b0
`define PCSE_RST_LEVEL 1'b1
`define PCSE_RST_SET   1'b0
`define PCSE_OFF_PDEN  1'b0
`define PCSE_OFF_DIR   1'b1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCSE_CLK_NS        10
`define PCSE_FAST_TICK_NS  30500
`define PCSE_FAST_DEB_NS   91500
`define PCSE_SLOW_TICK_MS  50
`define PCSE_SLOW_DEB_MS   150
`define PCSE_FAST_TICK_CYC (`PCSE_FAST_TICK_NS / `PCSE_CLK_NS)
`define PCSE_SLOW_TICK_CYC (`PCSE_SLOW_TICK_MS * 1000000 / `PCSE_CLK_NS)
`define PCSE_DEB_SAMPLES   (`PCSE_SLOW_DEB_MS / `PCSE_SLOW_TICK_MS)

`endif

// >>> pkg/pcse_pkg.sv
package pcse_pkg;

    typedef struct packed {
        logic sleep;
        logic sel;
        logic deb;
        logic pden;
        logic dir;
        logic set;
    } pcse_pad_s;

    typedef struct packed {
        pcse_pad_s [2:0] pad;
        logic            boot_pend;
        logic [2:0]      sync1;
        logic [2:0]      sync2;
        logic [11:0]     fast_cnt;
        logic [22:0]     slow_cnt;
        logic            fast_tick;
        logic            slow_tick;
        logic [7:0]      rdata;
        logic            slverr;
        logic [2:0]      pad_out;
        logic [2:0]      pad_oe;
        logic [2:0]      pad_pd;
    } pcse_top_s;

    typedef struct packed {
        logic [1:0] cnt;
        logic       cand;
        logic       level;
    } pcse_deb_s;

endpackage

// >>> core/pcse_debounce.sv
`timescale 1ns/1ps
`include "pcse_cfg.svh"

module pcse_debounce (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_raw,
    input  wire logic i_tick,
    output logic      o_level
);

    localparam logic [1:0] LAST = 2'(`PCSE_DEB_SAMPLES);

    pcse_pkg::pcse_deb_s s;
    pcse_pkg::pcse_deb_s next_s;

    // ------------------------------------------------------------
    // three equal samples on the selected tick move the level
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (i_tick) begin
            if (i_raw != s.cand) begin
                next_s.cand = i_raw;
                next_s.cnt  = 2'h1;
            end else if (s.cnt != LAST) begin
                next_s.cnt = s.cnt + 2'h1;
                if (s.cnt + 2'h1 == LAST) begin
                    next_s.level = s.cand;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s.cnt   <= 2'h3;
            s.cand  <= `PCSE_RST_LEVEL;
            s.level <= `PCSE_RST_LEVEL;
        end else begin
            s <= next_s;
        end
    end

    assign o_level = s.level;

    property p_deb_on_tick;
        @(posedge i_clk) disable iff (!i_rst_b)
        $changed(s.level) |-> $past(i_tick);
    endproperty
    a_deb_on_tick: assert property (p_deb_on_tick)
        else $error("level moved without a tick");

    property p_deb_three;
        @(posedge i_clk) disable iff (!i_rst_b)
        $changed(s.level) |-> ($past(s.cnt) == 2'h2 && s.cnt == 2'h3);
    endproperty
    a_deb_three: assert property (p_deb_three)
        else $error("level moved before three equal samples");

endmodule

// >>> tb/pcse_pad_model.sv
`timescale 1ns/1ps

module pcse_pad_model (
    input  wire logic       i_clk,
    input  wire logic [2:0] i_out,
    input  wire logic [2:0] i_oe,
    input  wire logic [2:0] i_pd,
    input  wire logic [2:0] i_ext_en,
    input  wire logic [2:0] i_ext_lvl,
    output logic      [2:0] o_level
);
    // a floating pad without pulldown wanders each cycle, so no stale level can pass
    logic [2:0] drift = 3'h0;

    always @(posedge i_clk) begin
        drift <= ~drift;
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            o_level[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext_lvl[i] : i_pd[i] ? 1'b0 : drift[i];
        end
    end
endmodule

// >>> tb/pcse_top_tb.sv
`timescale 1ns/1ps
`include "pcse_cfg.svh"

module pcse_top_tb;
    logic        clk      = 1'b0;
    logic        rst_b    = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  pad_in;
    logic [2:0]  pad_out;
    logic [2:0]  pad_oe;
    logic [2:0]  pad_pd;
    logic        pwm      = 1'b0;
    logic        sleep    = 1'b0;
    logic        pwr_off  = 1'b0;
    logic [1:0]  seq      = 2'h0;
    logic [1:0]  boot_dir = 2'h0;
    logic [2:0]  ext_en   = 3'h7;
    logic [2:0]  ext_lvl  = 3'h7;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          exp_reg [3];
    logic [31:0] rd;
    logic        err;

    always #5 clk = ~clk;

    pcse_top #(.FAST_TICK_CYC(4), .SLOW_TICK_CYC(8)) uut (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out),
        .O_PAD_OE(pad_oe), .O_PAD_PD(pad_pd), .I_PWM(pwm), .I_SLEEP(sleep),
        .I_PWR_OFF_RST(pwr_off), .I_SEQ_ASSIGN(seq), .I_BOOT_DIR(boot_dir));

    pcse_pad_model partner (
        .i_clk(clk), .i_out(pad_out), .i_oe(pad_oe), .i_pd(pad_pd),
        .i_ext_en(ext_en), .i_ext_lvl(ext_lvl), .o_level(pad_in));

    task automatic print_verdict();
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_pad(input string name, input logic [2:0] exp, input logic [2:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [11:0] addr(input int i);
        return 12'((`PCSE_PIN6_IDX + i) * 4);
    endfunction

    // pads six and seven own the sleep bit, pad eight the source select
    task automatic reg_wr(input int i, input logic [31:0] d);
        apb(1'b1, addr(i), d);
        exp_reg[i] = int'(d) & ((i < 2) ? 'h9D : 'h3D);
    endtask

    task automatic reg_rd(input int i);
        apb(1'b0, addr(i), 32'h0);
        check_reg("config", exp_reg[i], rd & 32'hFFFFFFFD);
        check_reg("slverr", 32'h0, {31'h0, err});
    endtask

    task automatic lvl(input int i, input logic v);
        apb(1'b0, addr(i), 32'h0);
        check_reg("pad_level", {31'h0, v}, {31'h0, rd[1]});
    endtask

    task automatic pads();
        logic [2:0] oe;
        logic [2:0] pd;
        logic [2:0] out;
        logic       frc;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            frc    = (i < 2) && exp_reg[i][7] && sleep;
            oe[i]  = exp_reg[i][2] | frc;
            pd[i]  = exp_reg[i][3];
            out[i] = frc ? 1'b0 : (i == 2 && exp_reg[i][5]) ? pwm : exp_reg[i][0];
        end
        check_pad("pad_oe", oe, pad_oe);
        check_pad("pad_pd", pd, pad_pd);
        check_pad("pad_out", out & oe, pad_out & oe);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h6bb9));
        exp_reg = '{'h08, 'h08, 'h08};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            reg_rd(i);
            lvl(i, 1'b1);
        end
        pads();
        for (int i = 0; i < 3; i++) begin
            reg_wr(i, 32'hFFFFFFFF);
            reg_rd(i);
        end
        for (int v = 0; v < 2; v++) begin
            pwm <= v[0];
            pads();
        end
        repeat (12) begin
            pwm <= 1'($urandom);
            reg_wr($urandom_range(2), $urandom);
            reg_rd(0);
            pads();
        end
        reg_wr(0, 32'h05);
        reg_wr(1, 32'h89);
        sleep <= 1'b1;
        pads();
        reg_wr(0, 32'h85);
        pads();
        sleep <= 1'b0;
        pads();
        reg_wr(1, 32'h08);
        repeat (24) @(posedge clk);
        lvl(1, 1'b1);
        ext_lvl[1] <= 1'b0;
        repeat (5) @(posedge clk);
        lvl(1, 1'b1);
        repeat (20) @(posedge clk);
        lvl(1, 1'b0);
        reg_wr(1, 32'h18);
        ext_lvl[1] <= 1'b1;
        repeat (12) @(posedge clk);
        lvl(1, 1'b0);
        repeat (40) @(posedge clk);
        lvl(1, 1'b1);
        reg_wr(0, 32'h09);
        seq     <= 2'h1;
        pwr_off <= 1'b1;
        @(posedge clk);
        pwr_off <= 1'b0;
        exp_reg[0] = 'h04;
        reg_rd(0);
        reg_rd(1);
        pads();
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'h1A4 - 12'(k * 11), 32'hFF);
            check_reg("slverr", 32'h1, {31'h0, err});
            apb(1'b0, 12'h1A4 - 12'(k * 11), 32'h0);
            check_reg("unmapped", 32'h0, rd);
        end
        rst_b    <= 1'b0;
        boot_dir <= 2'h2;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        exp_reg = '{'h08, 'h0C, 'h08};
        pads();
        reg_rd(1);
        print_verdict();
    end
endmodule
